/* File: src/dmd_pkg.sv */
// constants and types for the data memory decode block
package dmd_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam int unsigned DMD_RAM_DEPTH  = 256;
  localparam int unsigned DMD_ADDR_W     = 8;
  localparam logic [7:0]  DMD_LOWER_TOP  = 8'h7F;
  localparam logic [7:0]  DMD_GPR_TOP    = 8'h1F;
  localparam logic [7:0]  DMD_BIT_BASE   = 8'h20;
  localparam logic [7:0]  DMD_BIT_TOP    = 8'h2F;
  localparam logic [7:0]  DMD_SFR_BITMSK = 8'hF8;
  localparam logic [7:0]  DMD_UID_BASE   = 8'hF0;

  // ****************************************************************
  // locally held special registers
  // ****************************************************************
  localparam logic [7:0]  DMD_SP_ADDR    = 8'h81;
  localparam logic [7:0]  DMD_PSW_ADDR   = 8'hD0;
  localparam logic [7:0]  DMD_SP_RESET   = 8'h07;
  localparam logic [7:0]  DMD_PSW_RESET  = 8'h00;
  localparam int unsigned DMD_RS0_POS    = 3;
  localparam int unsigned DMD_RS1_POS    = 4;

  // ****************************************************************
  // access kinds issued by the core
  // ****************************************************************
  typedef enum logic [2:0] {
    DMD_DIRECT,
    DMD_INDIRECT,
    DMD_REGOP,
    DMD_BITOP,
    DMD_PUSH,
    DMD_POP,
    DMD_XDPTR,
    DMD_XRI
  } dmd_mode_e;

  typedef enum logic {
    DMD_ST_IDLE,
    DMD_ST_SFR_WAIT
  } dmd_state_e;

endpackage : dmd_pkg

/* File: src/dmd_ram256.sv */
// 256 byte storage array with one write port and two read ports
`timescale 1ns/1ps
module dmd_ram256 (
  input  wire logic       mclk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr_a,
  output logic      [7:0] rd_data_a,
  input  wire logic [7:0] rd_addr_b,
  output logic      [7:0] rd_data_b
);
  import dmd_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem [DMD_RAM_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // reads see the old value during a write, so bit updates merge cleanly
  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule : dmd_ram256

/* File: src/dmd_top.sv */
// data memory decode: internal ram, banks, bits, stack, on-chip external ram
//
// Contract
// - 256 byte internal ram at 0x00..0xFF
// - lower half reached direct and indirect
// - upper half only indirect, separate from specials
// - direct above 0x7F goes to special registers
// - indirect above 0x7F goes to upper ram
// - 0x00..0x1F are four banks of eight
// - two status bits pick the one bank
// - indirect pointer is bank register zero/one
// - bit 0x00..0x7F maps into bytes 0x20..0x2F
// - bit operands do bit access, else bytes
// - push writes pointer plus one, then increments
// - reset loads stack pointer with 0x07
// - stack may use all 256 bytes
// - external move hits on-chip external ram
// - pointer upper byte ignored, 256 byte alias
// - top external bytes return unique identifier
// - only 0x0/0x8 specials are bit addressable
`timescale 1ns/1ps
module dmd_top #(
  // arbitrary value, stands in for the per-device identifier
  parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             req_valid,
  input  wire logic             req_write,
  input  wire dmd_pkg::dmd_mode_e req_mode,
  input  wire logic [15:0]      req_addr,
  input  wire logic [7:0]       req_wdata,
  input  wire logic             req_bitval,
  output logic                  busy_q,
  output logic                  rsp_valid_q,
  output logic [7:0]            rsp_data_q,
  output logic                  rsp_bit_q,
  output logic                  sfr_req_q,
  output logic                  sfr_we_q,
  output logic [7:0]            sfr_addr_q,
  output logic [7:0]            sfr_wdata_q,
  output logic                  sfr_bit_q,
  output logic [2:0]            sfr_bitpos_q,
  input  wire logic [7:0]       sfr_rdata,
  output logic [7:0]            stack_top_pointer_q,
  output logic [7:0]            processor_status_word_q
);
  import dmd_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // address of register idx in the bank chosen by the status word
  function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank,
                                               input logic [2:0] idx);
    bank_reg_addr = {3'b000, bank, idx};
  endfunction : bank_reg_addr

  // replace one bit of a byte
  function automatic logic [7:0] merge_bit(input logic [7:0] old_byte,
                                           input logic [2:0] pos,
                                           input logic       val);
    logic [7:0] res;
    res      = old_byte;
    res[pos] = val;
    merge_bit = res;
  endfunction : merge_bit

  // ****************************************************************
  // state and wires
  // ****************************************************************
  dmd_state_e state_q;
  dmd_state_e state_d;

  logic [7:0] sp_d;
  logic [7:0] psw_d;
  logic [1:0] bank;
  logic [7:0] ri_addr;
  logic [7:0] ri_val;
  logic [7:0] sp_inc;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic       take;

  logic [7:0] iram_addr;
  logic [7:0] iram_rd;
  logic       iram_we;
  logic [7:0] iram_wdata;
  logic [7:0] on_chip_external_ram_addr;
  logic [7:0] on_chip_external_ram_rd;
  logic       on_chip_external_ram_we;
  logic       on_chip_external_ram_uid;
  logic [7:0] uid_byte;

  logic       sel_iram;
  logic       sel_on_chip_external_ram;
  logic       sel_sp;
  logic       sel_psw;
  logic       sel_sfr;
  logic       is_bit;
  logic [7:0] sel_addr;
  logic [7:0] local_rd;
  logic [7:0] rd_byte;

  assign take    = req_valid && (state_q == DMD_ST_IDLE);
  assign bank    = {processor_status_word_q[DMD_RS1_POS],
                    processor_status_word_q[DMD_RS0_POS]};
  assign ri_addr = bank_reg_addr(bank, {2'b00, req_addr[0]});
  assign sp_inc  = stack_top_pointer_q + 8'h01;
  assign bit_pos = req_addr[2:0];

  // ****************************************************************
  // bit address decode
  // ****************************************************************
  always_comb begin
    if (req_addr[7]) begin
      // special bits only land on bytes ending in 0x0 or 0x8
      bit_byte = req_addr[7:0] & DMD_SFR_BITMSK;
    end else begin
      bit_byte = DMD_BIT_BASE + {4'h0, req_addr[6:3]};
    end
  end

  // ****************************************************************
  // target decode
  // ****************************************************************
  always_comb begin
    sel_iram  = 1'b0;
    sel_on_chip_external_ram  = 1'b0;
    sel_addr  = req_addr[7:0];
    is_bit    = 1'b0;
    iram_addr = sp_inc;
    on_chip_external_ram_addr = req_addr[7:0];
    unique case (req_mode)
      DMD_DIRECT: begin
        // above 0x7F direct goes to special registers
        sel_iram  = !req_addr[7];
        iram_addr = req_addr[7:0];
      end
      DMD_INDIRECT: begin
        // the full 256 bytes, upper half included
        sel_iram  = 1'b1;
        iram_addr = ri_val;
      end
      DMD_REGOP: begin
        sel_iram  = 1'b1;
        iram_addr = bank_reg_addr(bank, req_addr[2:0]);
      end
      DMD_BITOP: begin
        is_bit    = 1'b1;
        sel_iram  = !req_addr[7];
        sel_addr  = bit_byte;
        iram_addr = bit_byte;
      end
      DMD_PUSH: begin
        sel_iram  = 1'b1;
        iram_addr = sp_inc;
      end
      DMD_POP: begin
        sel_iram  = 1'b1;
        iram_addr = stack_top_pointer_q;
      end
      DMD_XDPTR: begin
        // upper pointer byte is a don't care
        sel_on_chip_external_ram  = 1'b1;
        on_chip_external_ram_addr = req_addr[7:0];
      end
      DMD_XRI: begin
        sel_on_chip_external_ram  = 1'b1;
        on_chip_external_ram_addr = ri_val;
      end
    endcase
  end

  // stack pointer and status word live here; other specials go out
  assign sel_sp  = !sel_iram && !sel_on_chip_external_ram && !is_bit && (sel_addr == DMD_SP_ADDR);
  assign sel_psw = !sel_iram && !sel_on_chip_external_ram && (sel_addr == DMD_PSW_ADDR);
  assign sel_sfr = !sel_iram && !sel_on_chip_external_ram && !sel_sp && !sel_psw;

  assign local_rd = sel_sp ? stack_top_pointer_q : processor_status_word_q;

  // ****************************************************************
  // storage
  // ****************************************************************
  assign iram_wdata = is_bit ? merge_bit(iram_rd, bit_pos, req_bitval)
                             : req_wdata;
  assign iram_we    = take && sel_iram && (req_write || req_mode == DMD_PUSH)
                      && req_mode != DMD_POP;

  // one port serves the target, the other the bank index register
  dmd_ram256 u_iram (
    .mclk      (mclk),
    .wr_en     (iram_we),
    .wr_addr   (iram_addr),
    .wr_data   (iram_wdata),
    .rd_addr_a (iram_addr),
    .rd_data_a (iram_rd),
    .rd_addr_b (ri_addr),
    .rd_data_b (ri_val)
  );

  // the identifier window is read-only, writes there are dropped
  assign on_chip_external_ram_uid = on_chip_external_ram_addr >= DMD_UID_BASE;
  assign uid_byte = UNIQUE_ID[{on_chip_external_ram_addr[3:0], 3'b000} +: 8];
  assign on_chip_external_ram_we  = take && sel_on_chip_external_ram && req_write && !on_chip_external_ram_uid;

  dmd_ram256 u_on_chip_external_ram (
    .mclk      (mclk),
    .wr_en     (on_chip_external_ram_we),
    .wr_addr   (on_chip_external_ram_addr),
    .wr_data   (req_wdata),
    .rd_addr_a (on_chip_external_ram_addr),
    .rd_data_a (on_chip_external_ram_rd),
    .rd_addr_b (8'h00),
    .rd_data_b ()
  );

  always_comb begin
    if (sel_on_chip_external_ram) begin
      rd_byte = on_chip_external_ram_uid ? uid_byte : on_chip_external_ram_rd;
    end else if (sel_iram) begin
      rd_byte = iram_rd;
    end else begin
      rd_byte = local_rd;
    end
  end

  // ****************************************************************
  // stack pointer
  // ****************************************************************
  always_comb begin
    sp_d = stack_top_pointer_q;
    if (take) begin
      if (req_mode == DMD_PUSH) begin
        sp_d = sp_inc;
      end else if (req_mode == DMD_POP) begin
        sp_d = stack_top_pointer_q - 8'h01;
      end else if (sel_sp && req_write) begin
        // software may place the stack anywhere, wrapping freely
        sp_d = req_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stack_top_pointer_q <= DMD_SP_RESET;
    end else begin
      stack_top_pointer_q <= sp_d;
    end
  end

  // ****************************************************************
  // status word
  // ****************************************************************
  always_comb begin
    psw_d = processor_status_word_q;
    if (take && sel_psw && req_write) begin
      psw_d = is_bit ? merge_bit(processor_status_word_q, bit_pos, req_bitval)
                     : req_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      processor_status_word_q <= DMD_PSW_RESET;
    end else begin
      processor_status_word_q <= psw_d;
    end
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DMD_ST_IDLE: begin
        if (take && sel_sfr) begin
          state_d = DMD_ST_SFR_WAIT;
        end
      end
      DMD_ST_SFR_WAIT: begin
        state_d = DMD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= DMD_ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d == DMD_ST_SFR_WAIT);
    end
  end

  // ****************************************************************
  // special register port
  // ****************************************************************
  // accesses to unoccupied addresses are passed through untouched
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sfr_req_q    <= 1'b0;
      sfr_we_q     <= 1'b0;
      sfr_addr_q   <= 8'h00;
      sfr_wdata_q  <= 8'h00;
      sfr_bit_q    <= 1'b0;
      sfr_bitpos_q <= 3'h0;
    end else if (take && sel_sfr) begin
      sfr_req_q    <= 1'b1;
      sfr_we_q     <= req_write;
      sfr_addr_q   <= sel_addr;
      sfr_wdata_q  <= is_bit ? {7'h00, req_bitval} : req_wdata;
      sfr_bit_q    <= is_bit;
      sfr_bitpos_q <= bit_pos;
    end else begin
      sfr_req_q    <= 1'b0;
      sfr_we_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // response
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_bit_q   <= 1'b0;
    end else if (state_q == DMD_ST_SFR_WAIT) begin
      rsp_valid_q <= 1'b1;
      rsp_data_q  <= sfr_rdata;
      rsp_bit_q   <= sfr_rdata[sfr_bitpos_q];
    end else if (take && !sel_sfr) begin
      rsp_valid_q <= 1'b1;
      rsp_data_q  <= rd_byte;
      rsp_bit_q   <= rd_byte[bit_pos];
    end else begin
      rsp_valid_q <= 1'b0;
    end
  end

endmodule : dmd_top

/* File: tb/dmd_checker.sv */
// port assertions for the data memory decode block
`timescale 1ns/1ps
module dmd_checker
  import dmd_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       req_valid,
  input wire dmd_mode_e  req_mode,
  input wire logic [15:0] req_addr,
  input wire logic       req_write,
  input wire logic [7:0] req_wdata,
  input wire logic       busy_q,
  input wire logic       rsp_valid_q,
  input wire logic [7:0] rsp_data_q,
  input wire logic       sfr_req_q,
  input wire logic       sfr_we_q,
  input wire logic [7:0] sfr_addr_q,
  input wire logic [7:0] sfr_wdata_q,
  input wire logic       sfr_bit_q,
  input wire logic [2:0] sfr_bitpos_q,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] stack_top_pointer_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = req_valid && !busy_q;
  sequence s_sfr_answer;
    busy_q ##1 (rsp_valid_q && !busy_q && rsp_data_q == $past(sfr_rdata));
  endsequence
  AST_SP_RESET: assert property (
    $rose(reset_n) |-> stack_top_pointer_q == 8'h07) else $error("reset stack value wrong");
  AST_PUSH_INC: assert property (
    take && req_mode == DMD_PUSH |=> stack_top_pointer_q == $past(stack_top_pointer_q) + 8'h01)
    else $error("push did not increment");
  AST_POP_DEC: assert property (
    take && req_mode == DMD_POP |=> stack_top_pointer_q == $past(stack_top_pointer_q) - 8'h01)
    else $error("pop did not decrement");
  AST_DIRECT_SFR: assert property (
    take && req_mode == DMD_DIRECT && req_addr[7] && req_addr[7:0] != 8'h81
    && req_addr[7:0] != 8'hD0 |=> sfr_req_q && sfr_addr_q == $past(req_addr[7:0]))
    else $error("direct high access not sent to special port");
  AST_SFR_WRITE: assert property (
    take && req_mode == DMD_DIRECT && req_addr[7] && req_addr[7:0] != 8'h81
    && req_addr[7:0] != 8'hD0 |=> sfr_we_q == $past(req_write)
    && sfr_wdata_q == $past(req_wdata)) else $error("special write qualifiers wrong");
  AST_BIT_SFR: assert property (
    take && req_mode == DMD_BITOP && req_addr[7] && req_addr[7:3] != 5'h1A |=> sfr_req_q
    && sfr_bit_q && sfr_addr_q == {$past(req_addr[7:3]), 3'h0}
    && sfr_bitpos_q == $past(req_addr[2:0])) else $error("bit special access wrong");
  AST_INTERNAL: assert property (
    take && (req_mode inside {DMD_INDIRECT, DMD_REGOP, DMD_PUSH, DMD_POP, DMD_XDPTR, DMD_XRI}
    || (req_mode == DMD_DIRECT && !req_addr[7])) |=> rsp_valid_q && !sfr_req_q && !busy_q)
    else $error("internal access not answered locally");
  AST_SFR_ANSWER: assert property (
    sfr_req_q |-> s_sfr_answer) else $error("special answer wrong");
  AST_BUSY_SHORT: assert property (
    busy_q |=> !busy_q) else $error("busy longer than one cycle");
endmodule : dmd_checker

/* File: tb/dmd_sfr_model.sv */
// responder model for the special register port
`timescale 1ns/1ps
module dmd_sfr_model (
  input  wire logic       mclk,
  input  wire logic       sfr_req_q,
  input  wire logic [7:0] sfr_addr_q,
  output logic      [7:0] sfr_rdata
);
  logic [7:0] noise_q = 8'h00;
  always @(posedge mclk) begin
    noise_q <= noise_q + 8'h35;
  end
  // answers in the request cycle, a moving pattern otherwise
  assign sfr_rdata = sfr_req_q ? ~sfr_addr_q : noise_q;
endmodule : dmd_sfr_model

/* File: tb/dmd_top_bench.sv */
// self-checking bench for the data memory decode block
`timescale 1ns/1ps
module dmd_top_bench;
  import dmd_pkg::*;
  // arbitrary value for the identifier
  localparam logic [127:0] UID = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_F00F;
  logic mclk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_bitval = 1'b0;
  dmd_mode_e req_mode = DMD_DIRECT;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, sfr_rdata, sp, rd;
  logic busy_q, rsp_valid_q, rsp_bit_q, sfr_req_q, sfr_we_q, sfr_bit_q, rb;
  logic [7:0] rsp_data_q, sfr_addr_q, sfr_wdata_q, processor_status_word;
  logic [2:0] sfr_bitpos_q;
  int n_mismatch = 0, samples_checked = 0;
  always #50 mclk = ~mclk;
  dmd_top #(.UNIQUE_ID(UID)) dmd_top_inst (.mclk, .reset_n, .req_valid, .req_write,
    .req_mode, .req_addr, .req_wdata, .req_bitval, .busy_q, .rsp_valid_q, .rsp_data_q,
    .rsp_bit_q, .sfr_req_q, .sfr_we_q, .sfr_addr_q, .sfr_wdata_q, .sfr_bit_q, .sfr_bitpos_q,
    .sfr_rdata, .stack_top_pointer_q(sp), .processor_status_word_q(processor_status_word));
  dmd_sfr_model dmd_sfr_model_inst (.mclk, .sfr_req_q, .sfr_addr_q, .sfr_rdata);
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input dmd_mode_e m, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic b);
    int n;
    n = 0;
    while (busy_q !== 1'b0 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    req_valid = 1'b1;
    req_mode = m;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_bitval = b;
    @(negedge mclk);
    req_valid = 1'b0;
    while (rsp_valid_q !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk("answer", 8'h01, {7'h00, rsp_valid_q});
    rd = rsp_data_q;
    rb = rsp_bit_q;
    // let an edge pass so the next call never raises valid in this time step
    @(negedge mclk);
  endtask : acc
  task automatic rst;
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk("stack pointer", 8'h07, sp);
    chk("status word", 8'h00, processor_status_word);
  endtask : rst
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_stack;
    acc(DMD_PUSH, 1'b0, 16'h0000, 8'hA1, 1'b0);
    chk("sp push", 8'h08, sp);
    acc(DMD_DIRECT, 1'b0, 16'h0008, 8'h00, 1'b0);
    chk("first push", 8'hA1, rd);
    acc(DMD_PUSH, 1'b0, 16'h0000, 8'hA2, 1'b0);
    acc(DMD_POP, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk("pop data", 8'hA2, rd);
    acc(DMD_POP, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk("pop data", 8'hA1, rd);
    chk("sp pop", 8'h07, sp);
    acc(DMD_DIRECT, 1'b1, 16'h0081, 8'hFF, 1'b0);
    acc(DMD_PUSH, 1'b0, 16'h0000, 8'hC3, 1'b0);
    chk("sp wrap", 8'h00, sp);
    acc(DMD_DIRECT, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk("wrapped push", 8'hC3, rd);
    acc(DMD_POP, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk("sp unwrap", 8'hFF, sp);
  endtask : s_stack
  task automatic s_banks;
    for (int k = 0; k < 4; k++) begin
      acc(DMD_DIRECT, 1'b1, 16'h00D0, 8'(k << 3), 1'b0);
      chk("bank select", 8'(k << 3), processor_status_word);
      for (int r = 0; r < 8; r += 7) acc(DMD_REGOP, 1'b1, 16'(r), 8'(8'h40 + k * 8 + r), 1'b0);
    end
    // registers zero and seven of every bank
    for (int a = 0; a < 32; a += (a % 8 == 0) ? 7 : 1) begin
      acc(DMD_DIRECT, 1'b0, 16'(a), 8'h00, 1'b0);
      chk("bank reg", 8'(8'h40 + a), rd);
    end
  endtask : s_banks
  task automatic s_indirect;
    acc(DMD_DIRECT, 1'b1, 16'h00D0, 8'h10, 1'b0);
    acc(DMD_REGOP, 1'b1, 16'h0000, 8'h90, 1'b0);
    acc(DMD_REGOP, 1'b1, 16'h0001, 8'h40, 1'b0);
    acc(DMD_INDIRECT, 1'b1, 16'h0000, 8'h5A, 1'b0);
    acc(DMD_INDIRECT, 1'b1, 16'h0001, 8'h6B, 1'b0);
    acc(DMD_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk("upper ram", 8'h5A, rd);
    acc(DMD_DIRECT, 1'b0, 16'h0040, 8'h00, 1'b0);
    chk("lower direct", 8'h6B, rd);
    acc(DMD_DIRECT, 1'b0, 16'h0090, 8'h00, 1'b0);
    chk("special read", 8'h6F, rd);
    acc(DMD_DIRECT, 1'b1, 16'h00E0, 8'h77, 1'b0);
    chk("special wdata", 8'h77, sfr_wdata_q);
    acc(DMD_DIRECT, 1'b0, 16'h0010, 8'h00, 1'b0);
    chk("index reg", 8'h90, rd);
  endtask : s_indirect
  task automatic s_bits;
    acc(DMD_DIRECT, 1'b1, 16'h0022, 8'h00, 1'b0);
    acc(DMD_BITOP, 1'b1, 16'h0013, 8'h00, 1'b1);
    acc(DMD_DIRECT, 1'b0, 16'h0022, 8'h00, 1'b0);
    chk("bit byte", 8'h08, rd);
    acc(DMD_DIRECT, 1'b1, 16'h002F, 8'h80, 1'b0);
    acc(DMD_BITOP, 1'b0, 16'h007F, 8'h00, 1'b0);
    chk("top bit", 8'h01, {7'h00, rb});
    acc(DMD_BITOP, 1'b0, 16'h007E, 8'h00, 1'b0);
    chk("next bit", 8'h00, {7'h00, rb});
    acc(DMD_BITOP, 1'b1, 16'h008B, 8'h00, 1'b1);
    chk("special bit addr", 8'h88, sfr_addr_q);
    chk("special bit data", 8'h01, sfr_wdata_q);
    acc(DMD_BITOP, 1'b1, 16'h00D3, 8'h00, 1'b1);
    chk("status bit write", 8'h18, processor_status_word);
    acc(DMD_BITOP, 1'b0, 16'h00D4, 8'h00, 1'b0);
    chk("status bit", 8'h01, {7'h00, rb});
  endtask : s_bits
  task automatic s_on_chip_external_ram;
    acc(DMD_XDPTR, 1'b1, 16'h0010, 8'h3C, 1'b0);
    acc(DMD_XDPTR, 1'b0, 16'hFF10, 8'h00, 1'b0);
    chk("alias", 8'h3C, rd);
    acc(DMD_REGOP, 1'b1, 16'h0001, 8'h10, 1'b0);
    acc(DMD_XRI, 1'b0, 16'h0001, 8'h00, 1'b0);
    chk("indexed on_chip_external_ram", 8'h3C, rd);
    acc(DMD_XDPTR, 1'b1, 16'h00F3, 8'h00, 1'b0);
    for (int k = 0; k < 16; k++) begin
      acc(DMD_XDPTR, 1'b0, 16'(16'h12F0 + k), 8'h00, 1'b0);
      chk("identifier", UID[k * 8 +: 8], rd);
    end
  endtask : s_on_chip_external_ram
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    @(negedge mclk);
    rst();
    s_stack();
    s_banks();
    s_indirect();
    s_bits();
    s_on_chip_external_ram();
    acc(DMD_PUSH, 1'b0, 16'h0000, 8'h11, 1'b0);
    rst();
    stop_test();
  end
endmodule : dmd_top_bench
bind dmd_top dmd_checker dmd_checker_inst (.mclk, .reset_n, .req_valid, .req_mode, .req_addr,
  .req_write, .req_wdata, .busy_q, .rsp_valid_q, .rsp_data_q, .sfr_req_q, .sfr_we_q,
  .sfr_addr_q, .sfr_wdata_q, .sfr_bit_q, .sfr_bitpos_q, .sfr_rdata, .stack_top_pointer_q);
